// File: design/hbc_boot_seq.v
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "hbc_map.vh"
// Notes on behaviour
// - reset low holds standby: ports floated, pll stopped, only reset watched
// - reset high runs the hub through its sub-stages
// - standby disables downstream ports, aborts transfers, returns registers to default
// - no configuration survives standby; all settings rebuilt after release
// - release enters flash probe; waits pll lock, defaults loaded
// - probe reads four signature bytes 2DFU from flash address 0x3fffa up
// - valid signature starts fetch at address zero, else go to rom defaults
// - flash reads support one, two and four data lines; dual is default
// - flash clock idles per mode 0 or mode 3
// - without flash strap the probe is skipped, rom path taken
// - rom stage loads default configuration values
// - strap stage samples config, port disable, non-removable, charging straps
// - config strap value 1 goes to smbus probe, else fuse merge
// - both smbus pins pulled up enables slave and host config, else merge
// - host configuration waits with no timeout
// - legacy mode ends host configuration on a write to register 0xff
// - non-legacy ends it on command 0xaa55 or 0xaa56
// - merge: fuse beats smbus under rom, smbus beats pseudo-fuse under flash
// - under flash code internal fuses ignored except id and phy trim
// - connect sets both attach bits, waits for upstream host to proceed
// - normal operation holds until reset low returns to standby or soft disconnect returns to connect
// - soft disconnect returns to connect until it is released
module hbc_boot_seq #(
	parameter       NPORT    = 6,
	parameter [3:0] SPI_HALF = 4'h4,
	parameter [6:0] SMB_ADDR = 7'h2d  // slave address, arbitrary value
) (
	// clock and reset
	input  wire             sys_clk_in,
	input  wire             resetn_in,
	// register port
	input  wire [7:0]       reg_addr_in,
	input  wire [7:0]       reg_wdata_in,
	input  wire             reg_wr_in,
	input  wire             reg_rd_in,
	output reg  [7:0]       reg_rdata_out,
	// pll and straps (asynchronous)
	input  wire             pll_lock_in,
	input  wire             flash_boot_strap_in,
	input  wire [2:0]       configuration_select_straps_in,
	input  wire [NPORT-1:0] port_disable_plus_straps_in,
	input  wire [NPORT-1:0] port_disable_minus_straps_in,
	input  wire             nonremovable_strap_in,
	input  wire             charge_enable_strap_in,
	// fuse and pseudo-fuse data (same clock)
	input  wire             fuse_vld_in,
	input  wire [NPORT-1:0] fuse_pdis_in,
	input  wire [1:0]       fuse_feat_in,
	input  wire [7:0]       fuse_uid_in,
	input  wire [7:0]       fuse_trim_in,
	input  wire             pseudo_vld_in,
	input  wire [NPORT-1:0] pseudo_pdis_in,
	input  wire [1:0]       pseudo_feat_in,
	// upstream host (same clock)
	input  wire             host_run_in,
	input  wire             soft_disc_in,
	// serial flash
	output reg              flash_cs_n_out,
	output reg              flash_sclk_out,
	input  wire [3:0]       flash_d_in,
	output reg  [3:0]       flash_d_out,
	output reg  [3:0]       flash_d_oe_out,
	output reg  [7:0]       fetch_byte_out,
	output reg              fetch_vld_out,
	// smbus slave pins (open drain)
	input  wire             smb_scl_in,
	input  wire             smb_sda_in,
	output reg              smb_sda_out,
	output reg              smb_sda_oe_out,
	// hub status and configuration
	output reg  [3:0]       stage_out,
	output reg              pll_run_out,
	output reg              port_drive_en_out,
	output reg  [NPORT-1:0] ds_port_en_out,
	output reg              hub_connect_attach_out,
	output reg              superspeed_hub_enable_bit_out,
	output reg  [NPORT-1:0] cfg_pdis_out,
	output reg              cfg_nonrem_out,
	output reg              cfg_bc_out,
	output reg  [7:0]       uid_out,
	output reg  [7:0]       trim_out
);

	// one-hot stages
	localparam [8:0] S_STBY   = 9'h001;
	localparam [8:0] S_PROBE  = 9'h002;
	localparam [8:0] S_ROM    = 9'h004;
	localparam [8:0] S_STRAP  = 9'h008;
	localparam [8:0] S_SMBCHK = 9'h010;
	localparam [8:0] S_SMBCFG = 9'h020;
	localparam [8:0] S_MERGE  = 9'h040;
	localparam [8:0] S_CONN   = 9'h080;
	localparam [8:0] S_NORM   = 9'h100;
	localparam integer PU_CYC = (`HBC_PULLUP_NS * `HBC_CLK_MHZ + 999) / 1000;
	localparam [7:0] PU_LAST  = PU_CYC[7:0] - 8'h01;
	localparam SW = 2 * NPORT + 13;

	function [3:0] stage_code;
		input [8:0] s;
		begin
			case (s)
				S_PROBE:  stage_code = `HBC_SC_PROBE;
				S_ROM:    stage_code = `HBC_SC_ROM;
				S_STRAP:  stage_code = `HBC_SC_STRAP;
				S_SMBCHK: stage_code = `HBC_SC_SMBCHK;
				S_SMBCFG: stage_code = `HBC_SC_SMBCFG;
				S_MERGE:  stage_code = `HBC_SC_MERGE;
				S_CONN:   stage_code = `HBC_SC_CONN;
				S_NORM:   stage_code = `HBC_SC_NORM;
				default:  stage_code = `HBC_SC_STBY;
			endcase
		end
	endfunction

	// data lines per flash clock for a width code
	function [3:0] wid_bits;
		input [1:0] w;
		begin
			case (w)
				`HBC_WID_DUAL: wid_bits = 4'h2;
				`HBC_WID_QUAD: wid_bits = 4'h4;
				default:       wid_bits = 4'h1;
			endcase
		end
	endfunction

	function [7:0] sig_byte;
		input [1:0] i;
		begin
			case (i)
				2'h0:    sig_byte = `HBC_SIG0;
				2'h1:    sig_byte = `HBC_SIG1;
				2'h2:    sig_byte = `HBC_SIG2;
				default: sig_byte = `HBC_SIG3;
			endcase
		end
	endfunction

	// two-flop synchronisers for every pin input; straps are static so a bus is safe
	wire [SW-1:0] a_raw = {flash_d_in, smb_sda_in, smb_scl_in, charge_enable_strap_in,
		nonremovable_strap_in, port_disable_minus_straps_in,
		port_disable_plus_straps_in, configuration_select_straps_in,
		flash_boot_strap_in, pll_lock_in};
	reg  [SW-1:0] a_meta_r;
	reg  [SW-1:0] a_s_r;
	always @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			a_meta_r <= {SW{1'b0}};
			a_s_r    <= {SW{1'b0}};
		end else begin
			a_meta_r <= a_raw;
			a_s_r    <= a_meta_r;
		end
	end
	wire             lock_s = a_s_r[0];
	wire             fstr_s = a_s_r[1];
	wire [2:0]       cfgs_s = a_s_r[4:2];
	wire [NPORT-1:0] pp_s   = a_s_r[NPORT+4:5];
	wire [NPORT-1:0] pm_s   = a_s_r[2*NPORT+4:NPORT+5];
	wire             nrem_s = a_s_r[2*NPORT+5];
	wire             bc_s   = a_s_r[2*NPORT+6];
	wire             scl_s  = a_s_r[2*NPORT+7];
	wire             sda_s  = a_s_r[2*NPORT+8];
	wire [3:0]       din_s  = a_s_r[2*NPORT+12:2*NPORT+9];

	// state and cross-block controls
	reg  [8:0] st_r;
	reg  [8:0] st_nxt;
	reg  [7:0] ctrl_r;
	reg        started_r;
	reg        flash_exec_r;
	reg  [7:0] pu_r;
	reg        smb_en_r;
	reg        smb_end_r;
	reg        smb_wr_r;
	reg  [7:0] smb_reg_r;
	reg  [7:0] smb_dat_r;
	reg        sp_busy_r;
	reg        sp_done_r;
	reg        sig_ok_r;
	wire       legacy  = ctrl_r[`HBC_CTRL_LEGACY];
	wire [1:0] ctl_wid = ctrl_r[`HBC_CTRL_WID_HI:`HBC_CTRL_WID_LO];
	wire probe_go = st_r[1] & lock_s & fstr_s & ~started_r;
	wire fetch_go = st_r[1] & sp_done_r & sig_ok_r;
	wire spi_go   = probe_go | fetch_go;
	wire pu_done  = st_r[4] & (pu_r == PU_LAST);
	wire smb_pass = pu_done & scl_s & sda_s;

	// stage sequencing
	always @* begin
		st_nxt = st_r;
		case (st_r)
			S_STBY:  st_nxt = S_PROBE;
			S_PROBE: begin
				if (lock_s & ~fstr_s)
					st_nxt = S_ROM;
				else if (sp_done_r)
					st_nxt = sig_ok_r ? S_STRAP : S_ROM;
			end
			S_ROM:   st_nxt = S_STRAP;
			S_STRAP: st_nxt = (cfgs_s == `HBC_CFG_SMB) ? S_SMBCHK : S_MERGE;
			S_SMBCHK: begin
				if (pu_done)
					st_nxt = smb_pass ? S_SMBCFG : S_MERGE;
			end
			S_SMBCFG: begin
				if (smb_end_r)
					st_nxt = S_MERGE; // no timeout here
			end
			S_MERGE: st_nxt = S_CONN;
			S_CONN: begin
				if (host_run_in & ~soft_disc_in)
					st_nxt = S_NORM;
			end
			S_NORM: begin
				if (soft_disc_in)
					st_nxt = S_CONN;
			end
			default: st_nxt = S_STBY;
		endcase
	end

	// state register and hub status outputs; sync reset is the standby state
	always @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			st_r                          <= S_STBY;
			stage_out                     <= `HBC_SC_STBY;
			pll_run_out                   <= 1'b0;
			port_drive_en_out             <= 1'b0;
			ds_port_en_out                <= {NPORT{1'b0}};
			hub_connect_attach_out        <= 1'b0;
			superspeed_hub_enable_bit_out <= 1'b0;
			started_r                     <= 1'b0;
			flash_exec_r                  <= 1'b0;
			pu_r                          <= 8'h00;
		end else begin
			st_r              <= st_nxt;
			stage_out         <= stage_code(st_nxt);
			pll_run_out       <= 1'b1;
			port_drive_en_out <= 1'b1;
			ds_port_en_out    <= st_nxt[8] ? ~cfg_pdis_out : {NPORT{1'b0}};
			hub_connect_attach_out        <= (st_nxt[7] | st_nxt[8]) & ~soft_disc_in;
			superspeed_hub_enable_bit_out <= (st_nxt[7] | st_nxt[8]) & ~soft_disc_in;
			if (probe_go)
				started_r <= 1'b1;
			if (fetch_go)
				flash_exec_r <= 1'b1;
			pu_r <= st_r[4] ? pu_r + 8'h01 : 8'h00;
		end
	end

	// configuration store; reset values are the rom defaults
	reg smod_pdis_r;
	reg smod_feat_r;
	always @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			cfg_pdis_out   <= {NPORT{`HBC_ROM_PDIS_BIT}};
			{cfg_bc_out, cfg_nonrem_out} <= `HBC_ROM_FEAT;
			smod_pdis_r    <= 1'b0;
			smod_feat_r    <= 1'b0;
			uid_out        <= 8'h00;
			trim_out       <= 8'h00;
		end else begin
			case (st_r)
				S_ROM: begin
					cfg_pdis_out <= {NPORT{`HBC_ROM_PDIS_BIT}};
					{cfg_bc_out, cfg_nonrem_out} <= `HBC_ROM_FEAT;
				end
				S_STRAP: begin
					cfg_pdis_out   <= cfg_pdis_out | pp_s | pm_s;
					cfg_nonrem_out <= cfg_nonrem_out | nrem_s;
					cfg_bc_out     <= cfg_bc_out | bc_s;
				end
				S_SMBCFG: begin
					if (smb_wr_r & (smb_reg_r == `HBC_SMB_PDIS)) begin
						cfg_pdis_out <= smb_dat_r[NPORT-1:0];
						smod_pdis_r  <= 1'b1;
					end
					if (smb_wr_r & (smb_reg_r == `HBC_SMB_FEAT)) begin
						{cfg_bc_out, cfg_nonrem_out} <= smb_dat_r[1:0];
						smod_feat_r <= 1'b1;
					end
				end
				S_MERGE: begin
					uid_out  <= fuse_uid_in; // kept even under flash
					trim_out <= fuse_trim_in;
					if (~flash_exec_r & fuse_vld_in) begin
						cfg_pdis_out <= fuse_pdis_in;
						{cfg_bc_out, cfg_nonrem_out} <= fuse_feat_in;
					end
					if (flash_exec_r & pseudo_vld_in & ~smod_pdis_r)
						cfg_pdis_out <= pseudo_pdis_in;
					if (flash_exec_r & pseudo_vld_in & ~smod_feat_r)
						{cfg_bc_out, cfg_nonrem_out} <= pseudo_feat_in;
				end
				default: ;
			endcase
		end
	end

	// flash engine: cmd and address on d0, optional dummy, data at chosen width
	reg        sp_fetch_r;
	reg [3:0]  sp_div_r;
	reg        sp_ph_r;
	reg [5:0]  sp_idx_r;
	reg [31:0] sp_tx_r;
	reg [7:0]  sp_rx_r;
	reg [3:0]  sp_bits_r;
	reg [1:0]  sp_byte_r;
	reg        sp_bad_r;
	reg [1:0]  sp_wid_r;
	reg [7:0]  rx_nxt;
	wire [1:0] go_wid  = fetch_go ? ctl_wid : `HBC_WID_ONE;
	wire [7:0] go_op   = (go_wid == `HBC_WID_QUAD) ? `HBC_OP_RD4 :
		(go_wid == `HBC_WID_DUAL) ? `HBC_OP_RD2 : `HBC_OP_RD1;
	wire [23:0] go_adr = fetch_go ? `HBC_BOOT_ADDR : `HBC_SIG_ADDR;
	wire [5:0] dstart  = (sp_wid_r == `HBC_WID_ONE) ? `HBC_TX_BITS :
		`HBC_TX_BITS + `HBC_DUMMY;
	wire [3:0] bsum    = sp_bits_r + wid_bits(sp_wid_r);
	wire       mism    = rx_nxt != sig_byte(sp_byte_r);

	// shift received lines into the byte, msb first
	always @* begin
		case (sp_wid_r)
			`HBC_WID_DUAL: rx_nxt = {sp_rx_r[5:0], din_s[1:0]};
			`HBC_WID_QUAD: rx_nxt = {sp_rx_r[3:0], din_s};
			default:       rx_nxt = {sp_rx_r[6:0], din_s[1]};
		endcase
	end

	// sampling at the end of the high half lets the synchronised data settle;
	// this needs SPI_HALF of two or more
	always @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			sp_busy_r <= 1'b0; // any transfer in progress is dropped
			sp_done_r <= 1'b0;
			sig_ok_r  <= 1'b0;
			sp_fetch_r <= 1'b0;
			sp_div_r  <= 4'h0;
			sp_ph_r   <= 1'b0;
			sp_idx_r  <= 6'h00;
			sp_tx_r   <= 32'h00000000;
			sp_rx_r   <= 8'h00;
			sp_bits_r <= 4'h0;
			sp_byte_r <= 2'h0;
			sp_bad_r  <= 1'b0;
			sp_wid_r  <= `HBC_WID_ONE;
			flash_cs_n_out <= 1'b1;
			flash_sclk_out <= 1'b0;
			flash_d_out    <= 4'h0;
			flash_d_oe_out <= 4'h0;
			fetch_byte_out <= 8'h00;
			fetch_vld_out  <= 1'b0;
		end else begin
			sp_done_r     <= 1'b0;
			fetch_vld_out <= 1'b0;
			if (spi_go) begin
				sp_busy_r  <= 1'b1;
				sp_fetch_r <= fetch_go;
				sp_wid_r   <= go_wid;
				sp_div_r   <= 4'h0;
				sp_ph_r    <= 1'b0;
				sp_idx_r   <= 6'h00;
				sp_tx_r    <= {go_op, go_adr};
				sp_bits_r  <= 4'h0;
				sp_byte_r  <= 2'h0;
				sp_bad_r   <= 1'b0;
				flash_cs_n_out <= 1'b0;
				flash_sclk_out <= 1'b0;
				flash_d_out    <= {3'h0, go_op[7]};
				flash_d_oe_out <= 4'h1;
			end else if (sp_busy_r) begin
				if (sp_div_r == SPI_HALF - 4'h1) begin
					sp_div_r       <= 4'h0;
					sp_ph_r        <= ~sp_ph_r;
					flash_sclk_out <= ~sp_ph_r;
					if (sp_ph_r) begin
						if (sp_idx_r < dstart)
							sp_idx_r <= sp_idx_r + 6'h01;
						sp_tx_r     <= {sp_tx_r[30:0], 1'b0};
						flash_d_out <= {3'h0, sp_tx_r[30]};
						if (sp_idx_r == `HBC_TX_LAST)
							flash_d_oe_out <= 4'h0; // flash drives from here on
						if (sp_idx_r >= dstart) begin
							sp_rx_r   <= rx_nxt;
							sp_bits_r <= (bsum == 4'h8) ? 4'h0 : bsum;
						end
						if ((sp_idx_r >= dstart) & (bsum == 4'h8)) begin
							if (sp_fetch_r) begin
								fetch_byte_out <= rx_nxt; // execute in place, never ends
								fetch_vld_out  <= 1'b1;
							end else begin
								sp_byte_r <= sp_byte_r + 2'h1;
								sp_bad_r  <= sp_bad_r | mism;
								if (sp_byte_r == 2'h3) begin
									sp_busy_r      <= 1'b0;
									sp_done_r      <= 1'b1;
									sig_ok_r       <= ~(sp_bad_r | mism);
									flash_cs_n_out <= 1'b1;
								end
							end
						end
					end
				end else
					sp_div_r <= sp_div_r + 4'h1;
			end else
				flash_sclk_out <= ctrl_r[`HBC_CTRL_MODE3]; // idle level
		end
	end

	// smbus slave: detects start/stop, shifts bytes, acks own address
	reg       scl_p_r;
	reg       sda_p_r;
	reg       sm_act_r;
	reg [3:0] sm_bit_r;
	reg [7:0] sm_sh_r;
	reg [1:0] sm_cnt_r;
	reg [7:0] sm_b1_r;
	reg [7:0] sm_b2_r;
	wire s_start = scl_s & scl_p_r & sda_p_r & ~sda_s;
	wire s_stop  = scl_s & scl_p_r & ~sda_p_r & sda_s;
	wire s_rise  = scl_s & ~scl_p_r;
	wire s_fall  = ~scl_s & scl_p_r;
	wire adr_ok  = (sm_sh_r[7:1] == SMB_ADDR) & ~sm_sh_r[0];
	wire att_cmd = ~legacy & (sm_b1_r == `HBC_SMB_ATT_HI) &
		((sm_b2_r == `HBC_SMB_ATT_LO) | (sm_b2_r == `HBC_SMB_KEEP_LO));
	wire leg_end = legacy & (sm_b1_r == `HBC_SMB_END);
	wire keep    = sm_b2_r == `HBC_SMB_KEEP_LO;
	always @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			scl_p_r   <= 1'b0;
			sda_p_r   <= 1'b0;
			smb_en_r  <= 1'b0;
			smb_end_r <= 1'b0;
			smb_wr_r  <= 1'b0;
			smb_reg_r <= 8'h00;
			smb_dat_r <= 8'h00;
			sm_act_r  <= 1'b0;
			sm_bit_r  <= 4'h0;
			sm_sh_r   <= 8'h00;
			sm_cnt_r  <= 2'h0;
			sm_b1_r   <= 8'h00;
			sm_b2_r   <= 8'h00;
			smb_sda_out    <= 1'b0;
			smb_sda_oe_out <= 1'b0;
		end else begin
			scl_p_r   <= scl_s;
			sda_p_r   <= sda_s;
			smb_end_r <= 1'b0;
			smb_wr_r  <= 1'b0;
			if (smb_pass)
				smb_en_r <= 1'b1;
			if (~smb_en_r) begin
				sm_act_r       <= 1'b0;
				smb_sda_oe_out <= 1'b0;
			end else if (s_start) begin
				sm_act_r <= 1'b1;
				sm_bit_r <= 4'h0;
				sm_cnt_r <= 2'h0;
				smb_sda_oe_out <= 1'b0;
			end else if (s_stop) begin
				sm_act_r       <= 1'b0;
				smb_sda_oe_out <= 1'b0;
				if (((sm_cnt_r == 2'h2) | (sm_cnt_r == 2'h3)) & leg_end) begin
					smb_end_r <= 1'b1;
					smb_en_r  <= 1'b0;
				end else if ((sm_cnt_r == 2'h3) & att_cmd) begin
					smb_end_r <= 1'b1;
					smb_en_r  <= keep;
				end else if (sm_cnt_r == 2'h3) begin
					smb_wr_r  <= 1'b1;
					smb_reg_r <= sm_b1_r;
					smb_dat_r <= sm_b2_r;
				end
			end else if (sm_act_r & s_rise & (sm_bit_r < 4'h8)) begin
				sm_sh_r  <= {sm_sh_r[6:0], sda_s};
				sm_bit_r <= sm_bit_r + 4'h1;
			end else if (sm_act_r & s_fall & (sm_bit_r == 4'h8)) begin
				sm_bit_r <= 4'h9;
				if ((sm_cnt_r != 2'h0) | adr_ok) begin
					smb_sda_oe_out <= 1'b1; // pull low for ack
					if (sm_cnt_r == 2'h1)
						sm_b1_r <= sm_sh_r;
					if (sm_cnt_r == 2'h2)
						sm_b2_r <= sm_sh_r;
					if (sm_cnt_r != 2'h3)
						sm_cnt_r <= sm_cnt_r + 2'h1;
				end else
					sm_act_r <= 1'b0; // not our address or a read
			end else if (sm_act_r & s_fall & (sm_bit_r == 4'h9)) begin
				sm_bit_r       <= 4'h0;
				smb_sda_oe_out <= 1'b0;
			end
		end
	end

	// register port: control writes, status reads one cycle later
	always @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			ctrl_r        <= `HBC_CTRL_RST;
			reg_rdata_out <= 8'h00;
		end else begin
			if (reg_wr_in & (reg_addr_in == `HBC_CTRL_OFS))
				ctrl_r <= reg_wdata_in;
			reg_rdata_out <= 8'h00;
			if (reg_rd_in) begin
				case (reg_addr_in)
					`HBC_CTRL_OFS: reg_rdata_out <= ctrl_r;
					`HBC_STAT_OFS: reg_rdata_out <= {sig_ok_r, flash_exec_r,
						smb_en_r, 1'b0, stage_out};
					`HBC_PCFG_OFS: reg_rdata_out <= {{(8-NPORT){1'b0}}, cfg_pdis_out};
					`HBC_FEAT_OFS: reg_rdata_out <= {6'h00, cfg_bc_out, cfg_nonrem_out};
					default:       reg_rdata_out <= 8'h00;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// File: design/hbc_map.vh
`ifndef HBC_MAP_VH
`define HBC_MAP_VH
// register byte offsets
`define HBC_CTRL_OFS 8'h00
`define HBC_STAT_OFS 8'h04
`define HBC_PCFG_OFS 8'h08
`define HBC_FEAT_OFS 8'h0c
// control register fields and reset value
`define HBC_CTRL_LEGACY 0
`define HBC_CTRL_MODE3 1
`define HBC_CTRL_WID_HI 3
`define HBC_CTRL_WID_LO 2
`define HBC_CTRL_RST 8'h05
// flash data width codes
`define HBC_WID_ONE 2'h0
`define HBC_WID_DUAL 2'h1
`define HBC_WID_QUAD 2'h2
// stage codes
`define HBC_SC_STBY 4'h0
`define HBC_SC_PROBE 4'h1
`define HBC_SC_ROM 4'h2
`define HBC_SC_STRAP 4'h3
`define HBC_SC_SMBCHK 4'h4
`define HBC_SC_SMBCFG 4'h5
`define HBC_SC_MERGE 4'h6
`define HBC_SC_CONN 4'h7
`define HBC_SC_NORM 4'h8
// flash probe and fetch
`define HBC_SIG_ADDR 24'h03fffa
`define HBC_BOOT_ADDR 24'h000000
`define HBC_SIG0 8'h32
`define HBC_SIG1 8'h44
`define HBC_SIG2 8'h46
`define HBC_SIG3 8'h55
`define HBC_OP_RD1 8'h03
`define HBC_OP_RD2 8'h3b
`define HBC_OP_RD4 8'h6b
`define HBC_TX_LAST 6'h1f
`define HBC_TX_BITS 6'h20
`define HBC_DUMMY 6'h08
// configuration strap value that opens the smbus path
`define HBC_CFG_SMB 3'h1
// smbus end-of-configuration codes and config registers
`define HBC_SMB_END 8'hff
`define HBC_SMB_ATT_HI 8'haa
`define HBC_SMB_ATT_LO 8'h55
`define HBC_SMB_KEEP_LO 8'h56
`define HBC_SMB_PDIS 8'h00
`define HBC_SMB_FEAT 8'h01
// rom default values
`define HBC_ROM_PDIS_BIT 1'b0
`define HBC_ROM_FEAT 2'h0
// pull-up settle time
`define HBC_PULLUP_NS 1000
`define HBC_CLK_MHZ 100
`endif

// File: design/README_unused.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: tb/hbc_boot_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "hbc_map.vh"
module hbc_boot_monitor (
	// clock, reset and watched inputs
	input wire logic       sys_clk_in,
	input wire logic       resetn_in,
	input wire logic [2:0] configuration_select_straps_in,
	input wire logic       host_run_in,
	input wire logic       soft_disc_in,
	input wire logic       smb_scl_in,
	input wire logic       smb_sda_in,
	// watched outputs
	input wire logic [3:0] stage_out,
	input wire logic       pll_run_out,
	input wire logic       hub_connect_attach_out,
	input wire logic       superspeed_hub_enable_bit_out
);
	// one domain; reset low silences all but the standby check
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!resetn_in);
	standby_quiet_a: assert property (disable iff (1'b0)
		!resetn_in |=> stage_out == `HBC_SC_STBY && !pll_run_out && !hub_connect_attach_out)
		else $error("standby outputs not quiet");
	release_probe_a: assert property (
		$rose(resetn_in) |-> ##1 stage_out == `HBC_SC_PROBE)
		else $error("release did not enter probe");
	stage_arcs_a: assert property ($changed(stage_out) |->
		stage_out == $past(stage_out) + 4'h1 || stage_out == `HBC_SC_MERGE
		|| ($past(stage_out) == `HBC_SC_PROBE && stage_out == `HBC_SC_STRAP)
		|| ($past(stage_out) == `HBC_SC_NORM && stage_out == `HBC_SC_CONN))
		else $error("illegal stage change");
	strap_branch_a: assert property (stage_out == `HBC_SC_STRAP |=> stage_out ==
		(configuration_select_straps_in == `HBC_CFG_SMB ? `HBC_SC_SMBCHK : `HBC_SC_MERGE))
		else $error("wrong stage after straps");
	pullup_branch_a: assert property (
		stage_out == `HBC_SC_SMBCHK ##1 stage_out != `HBC_SC_SMBCHK
		|-> stage_out == (smb_scl_in && smb_sda_in ? `HBC_SC_SMBCFG : `HBC_SC_MERGE))
		else $error("wrong stage after pull-up probe");
	attach_bits_a: assert property (
		stage_out == `HBC_SC_CONN && $stable(stage_out) && !soft_disc_in && $stable(soft_disc_in)
		|-> hub_connect_attach_out && superspeed_hub_enable_bit_out)
		else $error("attach bits low in connect");
	connect_hold_a: assert property (
		stage_out == `HBC_SC_CONN && !host_run_in |=> stage_out == `HBC_SC_CONN)
		else $error("left connect without host");
	disc_back_a: assert property (
		stage_out == `HBC_SC_NORM && soft_disc_in |-> ##[1:2] stage_out == `HBC_SC_CONN)
		else $error("soft disconnect ignored");
endmodule
`default_nettype wire

// File: tb/hbc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module hbc_flash_model (
	// link from the design
	input wire logic        sclk_in,
	input wire logic        cs_n_in,
	input wire logic [3:0]  d_in,
	input wire logic [3:0]  oe_in,
	input wire logic        bad_in,
	// wire level and captured command
	output logic     [3:0]  d_out,
	output logic     [31:0] cmd_out
);
	logic [6:0]  n = 7'h0;
	logic [3:0]  q = 4'h0;
	logic [31:0] sig;
	// signature bytes; a spoilt last byte forces the rom path
	assign sig = {8'h32, 8'h44, 8'h46, bad_in ? 8'h00 : 8'h55};
	assign d_out = (oe_in & d_in) | (~oe_in & q);
	// rising edges counted, so idle-low and idle-high clocks both work
	always @(posedge sclk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			n <= 7'h0;
		end else begin
			n <= n + 7'h1;
			if (n < 7'd32) cmd_out <= {cmd_out[30:0], d_in[0]};
		end
	end
	// released lines toggle so a stale value never looks valid
	always @(negedge sclk_in or posedge cs_n_in) begin
		if (!cs_n_in && n >= 7'd32 && n < 7'd64) q <= {~q[3:2], sig[~n[4:0]], ~q[0]};
		else q <= ~q;
	end
endmodule
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "hbc_map.vh"
module tb;
	// stimulus
	logic       clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, fbs = 1'b0, fv = 1'b0;
	logic       pv = 1'b0, run = 1'b0, disc = 1'b0, scl = 1'b1, sda = 1'b1, bad = 1'b0;
	logic       nrm = 1'b0;
	logic [2:0] cfs = 3'h0;
	logic [5:0] pp = 6'h0, pm = 6'h0, fp = 6'h0, sp = 6'h0;
	logic [7:0] adr = 8'h0, wd = 8'h0, uid = 8'h0;
	int         miscompares = 0, n_checks = 0, nf = 0;
	// outputs and wire levels
	wire [7:0]  rdat, uido;
	wire [3:0]  fdi, fdo, foe, st;
	wire [5:0]  dsen, pdis;
	wire [31:0] fcmd;
	wire        csn, sclk, fvld, soe, pll, att, ss, nro, sdaw;
	assign sdaw = sda & ~soe;
	hbc_boot_seq i_hbc_boot_seq (
		.sys_clk_in(clk), .resetn_in(rstn), .reg_addr_in(adr), .reg_wdata_in(wd),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .pll_lock_in(1'b1),
		.flash_boot_strap_in(fbs), .configuration_select_straps_in(cfs),
		.port_disable_plus_straps_in(pp), .port_disable_minus_straps_in(pm),
		.nonremovable_strap_in(nrm), .charge_enable_strap_in(1'b0), .fuse_vld_in(fv),
		.fuse_pdis_in(fp), .fuse_feat_in(2'h0), .fuse_uid_in(uid), .fuse_trim_in(8'h0),
		.pseudo_vld_in(pv), .pseudo_pdis_in(sp), .pseudo_feat_in(2'h0), .host_run_in(run),
		.soft_disc_in(disc), .flash_cs_n_out(csn), .flash_sclk_out(sclk), .flash_d_in(fdi),
		.flash_d_out(fdo), .flash_d_oe_out(foe), .fetch_byte_out(), .fetch_vld_out(fvld),
		.smb_scl_in(scl), .smb_sda_in(sdaw), .smb_sda_out(), .smb_sda_oe_out(soe),
		.stage_out(st), .pll_run_out(pll), .port_drive_en_out(), .ds_port_en_out(dsen),
		.hub_connect_attach_out(att), .superspeed_hub_enable_bit_out(ss), .cfg_pdis_out(pdis),
		.cfg_nonrem_out(nro), .cfg_bc_out(), .uid_out(uido), .trim_out()
	);
	hbc_flash_model i_hbc_flash_model (.sclk_in(sclk), .cs_n_in(csn), .d_in(fdo),
		.oe_in(foe), .bad_in(bad), .d_out(fdi), .cmd_out(fcmd));
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (fvld === 1'b1) nf <= nf + 1;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wrap_up;
		if (miscompares == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// reset for ten cycles; outputs still quiet at the release edge
	task automatic boot(input logic f, input logic [2:0] c);
		@(posedge clk);
		rstn <= 1'b0;
		fbs <= f;
		cfs <= c;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		#1 chk({st, pll, csn, dsen}, 12'h040);
	endtask
	task automatic wait_st(input logic [3:0] s);
		int n;
		n = 0;
		while (st !== s && n < 3000) begin
			@(posedge clk);
			#1 n++;
		end
		chk(st, s);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		adr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdat, e);
	endtask
	// one byte and the ack slot, 125 ns a bit
	task automatic smb_tx(input logic [7:0] b);
		for (int i = 7; i >= -1; i--) begin
			sda <= (i < 0) ? 1'b1 : b[i];
			#31 scl <= 1'b1;
			#31 if (i < 0) chk(soe, 1'b1);
			#31.5 scl <= 1'b0;
			#31.5;
		end
	endtask
	task automatic smb_frame(input logic [7:0] b1, input logic [7:0] b2);
		sda <= 1'b0;
		#62.5 scl <= 1'b0;
		#31;
		smb_tx({7'h2d, 1'b0});
		smb_tx(b1);
		smb_tx(b2);
		sda <= 1'b0;
		#31 scl <= 1'b1;
		#62.5 sda <= 1'b1;
		#62.5;
	endtask
	task automatic t_standby;
		boot(1'b0, 3'h0);
		rd_chk(`HBC_CTRL_OFS, `HBC_CTRL_RST);
		wr_reg(`HBC_CTRL_OFS, 8'h00);
		rd_chk(`HBC_CTRL_OFS, 8'h00);
		rd_chk(8'h10, 8'h00);
		boot(1'b0, 3'h0);
		rd_chk(`HBC_CTRL_OFS, `HBC_CTRL_RST);
	endtask
	task automatic t_rom;
		pp <= 6'h05;
		pm <= 6'h10;
		nrm <= 1'b1;
		boot(1'b0, 3'h0);
		wait_st(`HBC_SC_CONN);
		chk({pdis, nro}, {6'h15, 1'b1});
		repeat (50) @(posedge clk);
		#1 chk({st, att, ss}, {`HBC_SC_CONN, 2'b11});
		run <= 1'b1;
		wait_st(`HBC_SC_NORM);
		repeat (2) @(posedge clk);
		#1 chk(dsen, 6'h2a);
		disc <= 1'b1;
		wait_st(`HBC_SC_CONN);
		repeat (20) @(posedge clk);
		#1 chk({att, ss}, 2'b00);
		disc <= 1'b0;
		wait_st(`HBC_SC_NORM);
		run <= 1'b0;
		fv <= 1'b1;
		fp <= 6'h21;
		scl <= 1'b0;
		boot(1'b0, `HBC_CFG_SMB);
		wait_st(`HBC_SC_CONN);
		chk(pdis, 6'h21);
		{fv, pp, pm, nrm, scl} <= 15'h1;
	endtask
	// widths one, two, four; the middle pass also sets the mode 3 bit, but the clock never idles
	task automatic t_flash;
		logic [7:0] ops [3];
		ops = '{`HBC_OP_RD1, `HBC_OP_RD2, `HBC_OP_RD4};
		pv <= 1'b1;
		sp <= 6'h0c;
		uid <= 8'h5a;
		for (int w = 0; w < 3; w++) begin
			boot(1'b1, 3'h0);
			wr_reg(`HBC_CTRL_OFS, {4'h0, w[1:0], w[0], 1'b1});
			wait_st(`HBC_SC_STRAP);
			chk(fcmd, {`HBC_OP_RD1, `HBC_SIG_ADDR});
			wait_st(`HBC_SC_CONN);
			repeat (600) @(posedge clk);
			chk(fcmd, {ops[w], `HBC_BOOT_ADDR});
		end
		chk(nf != 0, 1'b1);
		rd_chk(`HBC_STAT_OFS, 8'hc7);
		chk({pdis, uido}, {6'h0c, 8'h5a});
		pv <= 1'b0;
		bad <= 1'b1;
		boot(1'b1, 3'h0);
		wait_st(`HBC_SC_ROM);
		wait_st(`HBC_SC_CONN);
		rd_chk(`HBC_STAT_OFS, 8'h07);
		bad <= 1'b0;
	endtask
	// legacy end, then both attach commands
	task automatic t_smb;
		for (int m = 0; m < 3; m++) begin
			boot(1'b0, `HBC_CFG_SMB);
			if (m > 0) wr_reg(`HBC_CTRL_OFS, 8'h04);
			wait_st(`HBC_SC_SMBCFG);
			repeat (400) @(posedge clk);
			#1 chk(st, `HBC_SC_SMBCFG);
			smb_frame(`HBC_SMB_PDIS, 8'h3c);
			smb_frame(m == 0 ? `HBC_SMB_END : `HBC_SMB_ATT_HI,
				m == 1 ? `HBC_SMB_ATT_LO : `HBC_SMB_KEEP_LO);
			wait_st(`HBC_SC_CONN);
			if (m > 0) rd_chk(`HBC_STAT_OFS, {2'b00, m == 2, 5'h07});
			chk(pdis, 6'h3c);
		end
	endtask
	initial begin
		t_standby;
		t_rom;
		t_flash;
		t_smb;
		wrap_up;
	end
	// hang guard, well past the longest expected run
	initial begin
		#200000;
		miscompares++;
		wrap_up;
	end
endmodule
bind hbc_boot_seq hbc_boot_monitor i_hbc_boot_monitor (
	.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .host_run_in(host_run_in),
	.configuration_select_straps_in(configuration_select_straps_in),
	.soft_disc_in(soft_disc_in), .smb_scl_in(smb_scl_in), .smb_sda_in(smb_sda_in),
	.stage_out(stage_out), .pll_run_out(pll_run_out),
	.hub_connect_attach_out(hub_connect_attach_out),
	.superspeed_hub_enable_bit_out(superspeed_hub_enable_bit_out)
);
`default_nettype wire
